// File: jil_regs.svh
// Constants for the lane alignment and test pattern link.
`ifndef JIL_REGS_SVH
`define JIL_REGS_SVH
`define JIL_K28_5 8'hbc
`define JIL_K28_0 8'h1c
`define JIL_K28_3 8'h7c
`define JIL_K28_4 8'h9c
`define JIL_D21_5 8'hb5
`define JIL_ILA_LAST_MF 2'h3
`define JIL_CFG_FIRST 6'h02
`define JIL_CFG_LAST 6'h0f
`define JIL_CFG_CHK_IDX 4'hd
`define JIL_SYNC_MIN_FR 4
`define JIL_SYNC_HOLD 8
`define JIL_CGS_K_CNT 3'h4
`define JIL_K_MIN_1L 6'h09
`define JIL_K_MIN_2L 6'h11
`define JIL_K_MAX 6'h20
`define JIL_N_M1 5'h0f
`define JIL_JESDV 3'h1
`define JIL_SUBCLASSV 3'h1
`define JIL_PRBS_SEED 23'h7fffff
`endif

// File: jil_pkg.sv
// Types and the shared scrambler step of the lane alignment link.
package jil_pkg;
	typedef enum logic [2:0] {JIL_TP_NORMAL, JIL_TP_D215, JIL_TP_K285, JIL_TP_REPILA, JIL_TP_RAMP,
		JIL_TP_PRBS} jil_tp_t;
	typedef enum logic [1:0] {JIL_PRBS7, JIL_PRBS15, JIL_PRBS23} jil_prbs_t;
	typedef enum logic [1:0] {JIL_TX_CGS, JIL_TX_ILA, JIL_TX_DATA} jil_tx_state_t;
	typedef enum logic [1:0] {JIL_RX_HOLD, JIL_RX_CGS, JIL_RX_ILA, JIL_RX_DATA} jil_rx_state_t;

	// Self-synchronous 1 + x^14 + x^15 over one octet, MSB first; returns {state, octet}.
	function automatic logic [22:0] jil_scr_step(input logic [7:0] d, input logic [14:0] s,
		input logic desc);
		logic [14:0] st;
		logic [7:0] o;
		logic b;
		st = s;
		o = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			b = d[i] ^ st[13] ^ st[14];
			o[i] = b;
			st = {st[13:0], desc ? d[i] : b};
		end
		return {st, o};
	endfunction
endpackage

// File: jil_link_if.sv
// Lane octets and sync request between transmitter and receiver.
`timescale 1ns/1ps
`default_nettype none
interface jil_link_if;
	logic [7:0] lane0_data;
	logic lane0_k;
	logic [7:0] lane1_data;
	logic lane1_k;
	logic link_sync_request_n;
	modport tx (output lane0_data, output lane0_k, output lane1_data, output lane1_k,
		input link_sync_request_n);
	modport rx (input lane0_data, input lane0_k, input lane1_data, input lane1_k,
		output link_sync_request_n);
endinterface
`default_nettype wire

// File: jil_rx_end.sv
// Receiver end: sync request, ILA capture, descrambling and sample assembly.
`timescale 1ns/1ps
`default_nettype none
`include "jil_regs.svh"
module jil_rx_end
	import jil_pkg::*;
#(
	parameter int SYNC_HOLD = `JIL_SYNC_HOLD
) (
	input wire logic CLK,
	input wire logic RSTN,
	jil_link_if.rx LINK,
	input wire logic DUAL_LANE,
	input wire logic RESYNC,
	output logic [15:0] SAMPLE_OUT,
	output logic SAMPLE_VALID,
	output logic LINK_UP,
	output logic [5:0] CFG_K,
	output logic CFG_SCR,
	output logic CFG_ERR
);
	jil_rx_state_t st_r, st_nxt;
	logic [3:0] hold_r, hold_nxt, ci_r, ci_nxt;
	logic [2:0] kc_r, kc_nxt;
	logic [1:0] ac_r, ac_nxt;
	logic [7:0] sum_r, sum_nxt, msb_r, msb_nxt;
	logic [5:0] k_r, k_nxt;
	logic scr_r, scr_nxt, err_r, err_nxt, ph_r, ph_nxt, val_r, val_nxt;
	logic [15:0] out_r, out_nxt;
	logic [14:0] ds_r [2];
	logic [14:0] ds_nxt [2];
	logic [7:0] rx_oct [2];
	logic [7:0] d0, d1;
	logic [22:0] dr0, dr1;

	// Sum of the fields held in one configuration octet.
	function automatic logic [7:0] fsum(input logic [3:0] i, input logic [7:0] b);
		case (i)
			4'h1: fsum = {4'h0, b[7:4]} + {4'h0, b[3:0]};
			4'h2: fsum = {7'h00, b[6]} + {7'h00, b[5]} + {3'h0, b[4:0]};
			4'h3, 4'ha: fsum = {7'h00, b[7]} + {3'h0, b[4:0]};
			4'h5: fsum = {3'h0, b[4:0]};
			4'h7: fsum = {6'h00, b[7:6]} + {3'h0, b[4:0]};
			4'h8, 4'h9: fsum = {5'h00, b[7:5]} + {3'h0, b[4:0]};
			default: fsum = b;
		endcase
	endfunction

	always_comb begin
		rx_oct[0] = LINK.lane0_data;
		rx_oct[1] = LINK.lane1_data;
		st_nxt = st_r;
		hold_nxt = hold_r;
		kc_nxt = kc_r;
		ac_nxt = ac_r;
		ci_nxt = ci_r;
		sum_nxt = sum_r;
		k_nxt = k_r;
		scr_nxt = scr_r;
		err_nxt = err_r;
		ph_nxt = 1'b0;
		msb_nxt = msb_r;
		out_nxt = out_r;
		val_nxt = 1'b0;
		dr0 = jil_scr_step(rx_oct[0], ds_r[0], 1'b1);
		dr1 = jil_scr_step(rx_oct[1], ds_r[1], 1'b1);
		d0 = scr_r ? dr0[7:0] : rx_oct[0];
		d1 = scr_r ? dr1[7:0] : rx_oct[1];
		for (int l = 0; l < 2; l++) begin
			ds_nxt[l] = ds_r[l];
		end
		case (st_r)
			JIL_RX_HOLD: begin
				hold_nxt = hold_r + 4'h1;
				kc_nxt = 3'h0;
				if (hold_r >= 4'(SYNC_HOLD - 1)) begin
					st_nxt = JIL_RX_CGS;
				end
			end
			JIL_RX_CGS: begin
				if (LINK.lane0_k && LINK.lane0_data == `JIL_K28_5) begin
					kc_nxt = kc_r + 3'h1;
				end else begin
					kc_nxt = 3'h0;
				end
				if (kc_r == `JIL_CGS_K_CNT) begin
					st_nxt = JIL_RX_ILA;
					ac_nxt = 2'h0;
					ci_nxt = 4'hf;
					err_nxt = 1'b0;
				end
			end
			JIL_RX_ILA: begin
				// Plain ILA octets prime the descrambler so data descrambles from its first octet.
				for (int l = 0; l < 2; l++) begin
					ds_nxt[l] = {ds_r[l][6:0], rx_oct[l]};
				end
				if (LINK.lane0_k && LINK.lane0_data == `JIL_K28_4) begin
					ci_nxt = 4'h0;
					sum_nxt = 8'h00;
				end else if (ci_r <= `JIL_CFG_CHK_IDX) begin
					ci_nxt = ci_r + 4'h1;
					sum_nxt = sum_r + fsum(ci_r, rx_oct[0]);
					if (ci_r == 4'h3) begin
						scr_nxt = rx_oct[0][7];
					end
					if (ci_r == 4'h5) begin
						k_nxt = {1'b0, rx_oct[0][4:0]} + 6'h01;
					end
					if (ci_r == `JIL_CFG_CHK_IDX) begin
						ci_nxt = 4'hf;
						err_nxt = sum_r != rx_oct[0];
					end
				end
				if (LINK.lane0_k && LINK.lane0_data == `JIL_K28_3) begin
					ac_nxt = ac_r + 2'h1;
					if (ac_r == `JIL_ILA_LAST_MF) begin
						st_nxt = JIL_RX_DATA;
					end
				end
			end
			JIL_RX_DATA: begin
				if (scr_r) begin
					ds_nxt[0] = dr0[22:8];
					ds_nxt[1] = dr1[22:8];
				end
				if (DUAL_LANE) begin
					out_nxt = {d0, d1};
					val_nxt = 1'b1;
				end else begin
					ph_nxt = ~ph_r;
					msb_nxt = d0;
					if (ph_r) begin
						out_nxt = {msb_r, d0};
						val_nxt = 1'b1;
					end
				end
			end
			default: st_nxt = JIL_RX_HOLD;
		endcase
		if (RESYNC) begin
			st_nxt = JIL_RX_HOLD;
			hold_nxt = 4'h0;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			st_r <= JIL_RX_HOLD;
			hold_r <= 4'h0;
			kc_r <= 3'h0;
			ac_r <= 2'h0;
			ci_r <= 4'hf;
			sum_r <= 8'h00;
			k_r <= 6'h00;
			scr_r <= 1'b0;
			err_r <= 1'b0;
			ph_r <= 1'b0;
			msb_r <= 8'h00;
			out_r <= 16'h0000;
			val_r <= 1'b0;
			ds_r[0] <= 15'h0000;
			ds_r[1] <= 15'h0000;
		end else begin
			st_r <= st_nxt;
			hold_r <= hold_nxt;
			kc_r <= kc_nxt;
			ac_r <= ac_nxt;
			ci_r <= ci_nxt;
			sum_r <= sum_nxt;
			k_r <= k_nxt;
			scr_r <= scr_nxt;
			err_r <= err_nxt;
			ph_r <= ph_nxt;
			msb_r <= msb_nxt;
			out_r <= out_nxt;
			val_r <= val_nxt;
			ds_r[0] <= ds_nxt[0];
			ds_r[1] <= ds_nxt[1];
		end
	end

	assign LINK.link_sync_request_n = st_r != JIL_RX_HOLD && st_r != JIL_RX_CGS;
	assign SAMPLE_OUT = out_r;
	assign SAMPLE_VALID = val_r;
	assign LINK_UP = st_r == JIL_RX_DATA;
	assign CFG_K = k_r;
	assign CFG_SCR = scr_r;
	assign CFG_ERR = err_r;
endmodule
`default_nettype wire

// File: jil_tx_end.sv
// Transmit end: ILA content, scrambling and test patterns for one channel.
`timescale 1ns/1ps
`default_nettype none
`include "jil_regs.svh"
module jil_tx_end
	import jil_pkg::*;
#(
	parameter int SYNC_MIN_FRAMES = `JIL_SYNC_MIN_FR
) (
	input wire logic CLK,
	input wire logic RSTN,
	jil_link_if.tx LINK,
	input wire logic [15:0] SAMPLE,
	output logic SAMPLE_TAKE,
	input wire logic DUAL_LANE,
	input wire logic SCR_EN,
	input wire logic [5:0] K_FRAMES,
	input wire jil_tp_t TEST_MODE,
	input wire jil_prbs_t PRBS_ORDER,
	input wire logic [15:0] RAMP_STEP,
	output logic LINK_UP
);
	jil_tx_state_t st_r, st_nxt;
	logic cf_dual_r, cf_dual_nxt, cf_scr_r, cf_scr_nxt;
	logic [5:0] cf_k_r, cf_k_nxt;
	jil_tp_t cf_tp_r, cf_tp_nxt;
	jil_prbs_t cf_prbs_r, cf_prbs_nxt;
	logic [5:0] oct_r, oct_nxt;
	logic [1:0] mf_r, mf_nxt;
	logic [2:0] sy_r, sy_nxt;
	logic sync_lvl_r, sync_lvl_nxt;
	logic [3:0] low_r, low_nxt;
	logic [15:0] ramp_r, ramp_nxt;
	logic [7:0] hold_r, hold_nxt;
	logic [22:0] prbs_r, prbs_nxt;
	logic [14:0] scr_r [2];
	logic [14:0] scr_nxt [2];
	logic [7:0] ld_r [2];
	logic [7:0] ld_nxt [2];
	logic lk_r [2];
	logic lk_nxt [2];
	logic [6:0] mf_len;
	logic [3:0] thr;
	logic mf_last, fr_start, sync_req, scr_on;
	logic [15:0] smp;
	logic [7:0] pre;
	logic [8:0] ila;
	logic [22:0] sr;
	logic [30:0] pstep;

	// Advance the selected PRBS eight bits, MSB first; returns {state, octet}.
	function automatic logic [30:0] prbs_step(input logic [22:0] s, input jil_prbs_t ord);
		logic [22:0] st;
		logic [7:0] o;
		logic b;
		st = s;
		o = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			case (ord)
				JIL_PRBS15: b = st[14] ^ st[13];
				JIL_PRBS23: b = st[22] ^ st[17];
				default: b = st[6] ^ st[5];
			endcase
			o[i] = b;
			st = {st[21:0], b};
		end
		return {st, o};
	endfunction

	// Link configuration octet i (0 to 13) of the second ILA multiframe.
	function automatic logic [7:0] cfg_oct(input logic [3:0] i, input logic lid, input logic dual,
		input logic scr, input logic [5:0] k);
		logic [7:0] chk;
		// Field sum: LID + SCR + (L-1) + (F-1) + (K-1) + (N-1) + SUBCLASSV + (N'-1) + JESDV + HD.
		chk = {7'h00, lid} + {7'h00, scr} + {7'h00, dual} + {7'h00, ~dual} + {2'h0, k} - 8'h01
			+ {3'h0, `JIL_N_M1} + {5'h00, `JIL_SUBCLASSV} + {3'h0, `JIL_N_M1}
			+ {5'h00, `JIL_JESDV} + {7'h00, dual};
		case (i)
			4'h2: cfg_oct = {3'h0, 4'h0, lid};
			4'h3: cfg_oct = {scr, 6'h00, dual};
			4'h4: cfg_oct = {7'h00, ~dual};
			4'h5: cfg_oct = {2'h0, k - 6'h01};
			4'h7: cfg_oct = {3'h0, `JIL_N_M1};
			4'h8: cfg_oct = {`JIL_SUBCLASSV, `JIL_N_M1};
			4'h9: cfg_oct = {`JIL_JESDV, 5'h00};
			4'ha: cfg_oct = {dual, 7'h00};
			`JIL_CFG_CHK_IDX: cfg_oct = chk;
			default: cfg_oct = 8'h00;
		endcase
	endfunction

	// Control: sync filtering, multiframe counting, configuration latch and link state.
	always_comb begin
		mf_len = cf_dual_r ? {1'b0, cf_k_r} : {cf_k_r, 1'b0};
		mf_last = {1'b0, oct_r} == mf_len - 7'h01;
		fr_start = cf_dual_r | ~oct_r[0];
		sy_nxt = {sy_r[1:0], LINK.link_sync_request_n};
		sync_lvl_nxt = (sy_r[1] == sy_r[2]) ? sy_r[2] : sync_lvl_r;
		low_nxt = sync_lvl_r ? 4'h0 : (low_r == 4'hf ? low_r : low_r + 4'h1);
		thr = cf_dual_r ? 4'(SYNC_MIN_FRAMES) : 4'(2 * SYNC_MIN_FRAMES);
		sync_req = low_r >= thr;
		oct_nxt = mf_last ? 6'h00 : oct_r + 6'h01;
		cf_dual_nxt = cf_dual_r;
		cf_scr_nxt = cf_scr_r;
		cf_k_nxt = cf_k_r;
		cf_tp_nxt = cf_tp_r;
		cf_prbs_nxt = cf_prbs_r;
		if (mf_last) begin
			cf_dual_nxt = DUAL_LANE;
			cf_scr_nxt = SCR_EN;
			cf_prbs_nxt = PRBS_ORDER;
			// Out-of-range K is clamped so the multiframe always holds the ILA configuration.
			cf_k_nxt = K_FRAMES > `JIL_K_MAX ? `JIL_K_MAX : K_FRAMES;
			if (K_FRAMES < (DUAL_LANE ? `JIL_K_MIN_2L : `JIL_K_MIN_1L)) begin
				cf_k_nxt = DUAL_LANE ? `JIL_K_MIN_2L : `JIL_K_MIN_1L;
			end
			case (TEST_MODE)
				JIL_TP_D215, JIL_TP_K285, JIL_TP_REPILA, JIL_TP_RAMP, JIL_TP_PRBS: cf_tp_nxt = TEST_MODE;
				default: cf_tp_nxt = JIL_TP_NORMAL;
			endcase
		end
		st_nxt = st_r;
		mf_nxt = mf_r;
		case (st_r)
			JIL_TX_CGS: begin
				mf_nxt = 2'h0;
				if (sync_lvl_r && mf_last) begin
					st_nxt = JIL_TX_ILA;
				end
			end
			JIL_TX_ILA: begin
				if (mf_last) begin
					mf_nxt = mf_r + 2'h1;
					if (mf_r == `JIL_ILA_LAST_MF && cf_tp_r != JIL_TP_REPILA) begin
						st_nxt = JIL_TX_DATA;
					end
				end
				if (sync_req) begin
					st_nxt = JIL_TX_CGS;
				end
			end
			JIL_TX_DATA: begin
				if (sync_req) begin
					st_nxt = JIL_TX_CGS;
				end
			end
			default: st_nxt = JIL_TX_CGS;
		endcase
		if (cf_tp_r == JIL_TP_K285 || cf_tp_r == JIL_TP_PRBS) begin
			st_nxt = JIL_TX_CGS;
		end
	end

	// Lane content: sample framing, ILA octets, scrambler and pattern generators.
	always_comb begin
		smp = (cf_tp_r == JIL_TP_RAMP) ? ramp_r : SAMPLE;
		SAMPLE_TAKE = st_r == JIL_TX_DATA && fr_start && cf_tp_r == JIL_TP_NORMAL;
		ramp_nxt = ramp_r;
		if (st_r == JIL_TX_DATA && fr_start && cf_tp_r == JIL_TP_RAMP) begin
			ramp_nxt = ramp_r + RAMP_STEP;
		end
		hold_nxt = fr_start ? smp[7:0] : hold_r;
		pstep = prbs_step(prbs_r, cf_prbs_r);
		sr = pstep[30:8];
		prbs_nxt = (cf_tp_r == JIL_TP_PRBS) ? sr : prbs_r;
		scr_on = cf_scr_r && (cf_tp_r == JIL_TP_NORMAL || cf_tp_r == JIL_TP_RAMP);
		pre = 8'h00;
		ila = 9'h000;
		for (int l = 0; l < 2; l++) begin
			scr_nxt[l] = scr_r[l];
			ld_nxt[l] = 8'h00;
			lk_nxt[l] = 1'b0;
			pre = (l == 0) ? (fr_start ? smp[15:8] : hold_r) : smp[7:0];
			if (l == 0) begin
				ila = {1'b0, 2'h0, oct_r};
			end else begin
				ila = {1'b0, 2'h0, oct_r};
			end
			if (oct_r == 6'h00) begin
				ila = {1'b1, `JIL_K28_0};
			end else if ({1'b0, oct_r} == mf_len - 7'h01) begin
				ila = {1'b1, `JIL_K28_3};
			end else if (mf_r == 2'h1 && oct_r == 6'h01) begin
				ila = {1'b1, `JIL_K28_4};
			end else if (mf_r == 2'h1 && oct_r >= `JIL_CFG_FIRST && oct_r <= `JIL_CFG_LAST) begin
				ila = {1'b0, cfg_oct(4'(oct_r - `JIL_CFG_FIRST), l[0] & cf_dual_r, cf_dual_r, cf_scr_r, cf_k_r)};
			end
			if (l == 1 && !cf_dual_r) begin
				ld_nxt[l] = 8'h00;
			end else if (cf_tp_r == JIL_TP_K285) begin
				ld_nxt[l] = `JIL_K28_5;
				lk_nxt[l] = 1'b1;
			end else if (cf_tp_r == JIL_TP_PRBS) begin
				ld_nxt[l] = pstep[7:0];
			end else begin
				case (st_r)
					JIL_TX_ILA: begin
						ld_nxt[l] = ila[7:0];
						lk_nxt[l] = ila[8];
						// The history takes the plain ILA octets, as the receiver's descrambler does.
						scr_nxt[l] = {scr_r[l][6:0], ila[7:0]};
					end
					JIL_TX_DATA: begin
						if (cf_tp_r == JIL_TP_D215) begin
							ld_nxt[l] = `JIL_D21_5;
						end else if (scr_on) begin
							{scr_nxt[l], ld_nxt[l]} = jil_scr_step(pre, scr_r[l], 1'b0);
						end else begin
							ld_nxt[l] = pre;
						end
					end
					default: begin
						ld_nxt[l] = `JIL_K28_5;
						lk_nxt[l] = 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			st_r <= JIL_TX_CGS;
			cf_dual_r <= 1'b0;
			cf_scr_r <= 1'b0;
			cf_k_r <= `JIL_K_MIN_1L;
			cf_tp_r <= JIL_TP_NORMAL;
			cf_prbs_r <= JIL_PRBS7;
			oct_r <= 6'h00;
			mf_r <= 2'h0;
			sy_r <= 3'h7;
			sync_lvl_r <= 1'b1;
			low_r <= 4'h0;
			ramp_r <= 16'h0000;
			hold_r <= 8'h00;
			prbs_r <= `JIL_PRBS_SEED;
			for (int l = 0; l < 2; l++) begin
				scr_r[l] <= 15'h0000;
				ld_r[l] <= 8'h00;
				lk_r[l] <= 1'b0;
			end
		end else begin
			st_r <= st_nxt;
			cf_dual_r <= cf_dual_nxt;
			cf_scr_r <= cf_scr_nxt;
			cf_k_r <= cf_k_nxt;
			cf_tp_r <= cf_tp_nxt;
			cf_prbs_r <= cf_prbs_nxt;
			oct_r <= oct_nxt;
			mf_r <= mf_nxt;
			sy_r <= sy_nxt;
			sync_lvl_r <= sync_lvl_nxt;
			low_r <= low_nxt;
			ramp_r <= ramp_nxt;
			hold_r <= hold_nxt;
			prbs_r <= prbs_nxt;
			for (int l = 0; l < 2; l++) begin
				scr_r[l] <= scr_nxt[l];
				ld_r[l] <= ld_nxt[l];
				lk_r[l] <= lk_nxt[l];
			end
		end
	end

	assign LINK.lane0_data = ld_r[0];
	assign LINK.lane0_k = lk_r[0];
	assign LINK.lane1_data = ld_r[1];
	assign LINK.lane1_k = lk_r[1];
	assign LINK_UP = st_r == JIL_TX_DATA;
endmodule
`default_nettype wire

// File: jil_link_sva.sv
// Checker of the lane alignment link as seen on the wires between the two ends.
`timescale 1ns/1ps
`default_nettype none
`include "jil_regs.svh"
module jil_link_sva (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic [7:0] lane0_data,
	input wire logic lane0_k,
	input wire logic [7:0] lane1_data,
	input wire logic lane1_k,
	input wire logic link_sync_request_n
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	wire logic mk4 = lane0_k && lane0_data == `JIL_K28_4;
	wire logic mk5 = lane0_k && lane0_data == `JIL_K28_5;
	wire logic mk0 = lane0_k && lane0_data == `JIL_K28_0;

	property p_ila_ids;
		mk4 |=> (lane0_data == 8'h00) [*3];
	endproperty
	a_ila_ids: assert property (p_ila_ids) else $error("ila id octets not zero");
	property p_ila_dual;
		mk4 ##4 lane0_data[0] |-> ##1 lane0_data == 8'h00 ##6 lane0_data[7];
	endproperty
	a_ila_dual: assert property (p_ila_dual) else $error("dual lane frame fields wrong");
	property p_ila_single;
		mk4 ##4 !lane0_data[0] |-> ##1 lane0_data == 8'h01 ##6 !lane0_data[7];
	endproperty
	a_ila_single: assert property (p_ila_single) else $error("single lane frame fields wrong");
	property p_ila_counts;
		mk4 |-> ##7 lane0_data == 8'h00 ##1 lane0_data == 8'h0f ##1 lane0_data == 8'h2f ##1 lane0_data == 8'h20;
	endproperty
	a_ila_counts: assert property (p_ila_counts) else $error("converter count fields wrong");
	property p_ila_resv;
		mk4 |-> ##4 lane0_data[6:1] == 6'h00 ##7 lane0_data[6:0] == 7'h00 ##1 lane0_data == 8'h00 ##1 lane0_data == 8'h00;
	endproperty
	a_ila_resv: assert property (p_ila_resv) else $error("reserved ila fields not zero");
	property p_ila_k;
		mk4 |-> ##6 lane0_data inside {[8'h08:8'h1f]};
	endproperty
	a_ila_k: assert property (p_ila_k) else $error("frames per multiframe out of range");
	property p_lane1_id;
		lane1_k && lane1_data == `JIL_K28_4 |-> ##3 lane1_data == 8'h01;
	endproperty
	a_lane1_id: assert property (p_lane1_id) else $error("second lane id wrong");
	property p_sync_hold;
		$fell(link_sync_request_n) |-> (!link_sync_request_n) [*8];
	endproperty
	a_sync_hold: assert property (p_sync_hold) else $error("sync request too short");
	property p_sync_cgs;
		$fell(link_sync_request_n) |-> ##[1:30] mk5;
	endproperty
	a_sync_cgs: assert property (p_sync_cgs) else $error("no comma after sync request");
	property p_ila_start;
		mk5 ##1 !mk5 |-> mk0;
	endproperty
	a_ila_start: assert property (p_ila_start) else $error("comma not followed by ila start");
	c_dual: cover property (lane1_k && lane1_data == `JIL_K28_4);
	c_resync: cover property ($fell(link_sync_request_n));
	c_start: cover property (mk5 ##1 mk0);
endmodule
`default_nettype wire

// File: jesd_ila_and_test_patterns_tb.sv
// Self-checking bench joining the transmit and receive ends of the lane alignment link.
`timescale 1ns/1ps
`default_nettype none
`include "jil_regs.svh"
module jesd_ila_and_test_patterns_tb import jil_pkg::*;;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [15:0] sample = 16'h0000, ramp_step = 16'h0000, prev;
	logic dual = 1'b0, scr = 1'b0, resync = 1'b0, sync2_n = 1'b1, have_prev = 1'b0, pk5 = 1'b0;
	logic take, tx_up, tx2_up, rx_up, svalid, cerr, cscr;
	logic [5:0] kf = 6'h09, cfg_k;
	logic [15:0] sout;
	jil_tp_t mode = JIL_TP_NORMAL;
	jil_prbs_t order = JIL_PRBS7;
	int num_errors = 0, samples_checked = 0, cyc = 0, chk_mode = 0, t0 = 0, n3 = 0, n0 = 0, ila_len = 0, cap = 0;
	logic [7:0] cf0 [14], cf1 [14], hist [254];
	logic [15:0] q [$];
	always #20 clk = ~clk;
	jil_link_if u_jil_link_if ();
	jil_link_if u_jil_link_if_b ();
	assign u_jil_link_if_b.link_sync_request_n = sync2_n;
	wire logic [7:0] l0 = u_jil_link_if.lane0_data;
	wire logic k0 = u_jil_link_if.lane0_k;
	jil_tx_end u_jil_tx_end (.CLK(clk), .RSTN(rstn), .LINK(u_jil_link_if.tx), .SAMPLE(sample), .SAMPLE_TAKE(take),
		.DUAL_LANE(dual), .SCR_EN(scr), .K_FRAMES(kf), .TEST_MODE(mode), .PRBS_ORDER(order),
		.RAMP_STEP(ramp_step), .LINK_UP(tx_up));
	jil_tx_end u_jil_tx_end_b (.CLK(clk), .RSTN(rstn), .LINK(u_jil_link_if_b.tx), .SAMPLE(sample), .SAMPLE_TAKE(),
		.DUAL_LANE(dual), .SCR_EN(scr), .K_FRAMES(kf), .TEST_MODE(mode), .PRBS_ORDER(order),
		.RAMP_STEP(ramp_step), .LINK_UP(tx2_up));
	jil_rx_end u_jil_rx_end (.CLK(clk), .RSTN(rstn), .LINK(u_jil_link_if.rx), .DUAL_LANE(dual), .RESYNC(resync),
		.SAMPLE_OUT(sout), .SAMPLE_VALID(svalid), .LINK_UP(rx_up), .CFG_K(cfg_k), .CFG_SCR(cscr), .CFG_ERR(cerr));
	jil_link_sva u_jil_link_sva (.CLK(clk), .RSTN(rstn), .lane0_data(u_jil_link_if.lane0_data),
		.lane0_k(u_jil_link_if.lane0_k), .lane1_data(u_jil_link_if.lane1_data), .lane1_k(u_jil_link_if.lane1_k),
		.link_sync_request_n(u_jil_link_if.link_sync_request_n));

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic cycles(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wait_up();
		int i;
		i = 0;
		while (!(tx_up === 1'b1 && rx_up === 1'b1) && i < 3000) begin
			cycles(1);
			i++;
		end
		chk("link_up", {tx_up, rx_up}, 2'b11);
	endtask
	// Settings are only taken at a multiframe end, so wait longer than the largest multiframe first.
	task automatic run_cfg(input logic d, input logic s, input logic [5:0] k, input jil_tp_t m, input int cm);
		dual = d;
		scr = s;
		kf = k;
		mode = m;
		chk_mode = 0;
		cycles(80);
		if (m != JIL_TP_PRBS) begin
			resync = 1'b1;
			cycles(1);
			resync = 1'b0;
		end
		cycles(40);
		q.delete();
		if (!(m inside {JIL_TP_K285, JIL_TP_PRBS, JIL_TP_REPILA})) begin
			wait_up();
		end
		have_prev = 1'b0;
		chk_mode = cm;
		cycles(200);
	endtask
	task automatic chk_ila(input logic d, input logic s, input logic [5:0] k);
		logic [7:0] e;
		for (int ln = 0; ln < (d ? 2 : 1); ln++) begin
			for (int i = 0; i < 14; i++) begin
				case (i)
					2: e = 8'(ln);
					3: e = {s, 6'h00, d};
					4: e = {7'h00, !d};
					5: e = {2'b00, k - 6'h01};
					7: e = 8'h0f;
					8: e = 8'h2f;
					9: e = 8'h20;
					10: e = {d, 7'h00};
					13: e = 8'(ln + 2 * d + s + !d + k + 31);
					default: e = 8'h00;
				endcase
				chk("ila_octet", ln ? cf1[i] : cf0[i], {24'h0, e});
			end
		end
		chk("ila_len", ila_len, 4 * k * (d ? 1 : 2));
		chk("rx_cfg", {cerr, cscr, cfg_k}, {1'b0, s, k});
	endtask

	always @(negedge clk) sample <= sample + 16'h1357;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			stop_test();
		end
		if (take === 1'b1) q.push_back(sample);
		if (svalid === 1'b1 && chk_mode == 2) begin
			if (have_prev) chk("ramp", sout, 16'(prev + ramp_step));
			prev = sout;
			have_prev = 1'b1;
		end
		if (svalid === 1'b1 && q.size() > 0) begin
			prev = q.pop_front();
			if (chk_mode == 1) chk("sample", sout, prev);
		end
		if (cap > 0) begin
			cf0[14 - cap] = l0;
			cf1[14 - cap] = u_jil_link_if.lane1_data;
			cap--;
		end
		if (k0 && l0 == `JIL_K28_4) cap = 14;
		if (k0 && l0 == `JIL_K28_0 && pk5) begin
			t0 = cyc;
			n3 = 0;
		end
		if (k0 && l0 == `JIL_K28_0) n0++;
		if (k0 && l0 == `JIL_K28_3) begin
			n3++;
			if (n3 == 4) ila_len = cyc - t0 + 1;
		end
		pk5 = k0 && l0 == `JIL_K28_5;
	end

	initial begin
		cycles(20);
		rstn = 1'b1;
		wait_up();
		// The second transmitter sees a request too short to count, then a real one.
		sync2_n = 1'b0;
		cycles(6);
		sync2_n = 1'b1;
		cycles(30);
		chk("short_sync", tx2_up, 1'b1);
		sync2_n = 1'b0;
		cycles(30);
		chk("long_sync", {tx2_up, u_jil_link_if_b.lane0_k, u_jil_link_if_b.lane0_data}, {2'b01, `JIL_K28_5});
		sync2_n = 1'b1;
		chk_ila(1'b0, 1'b0, 6'h09);
		chk_mode = 1;
		cycles(200);
		for (int i = 0; i < 3; i++) begin
			run_cfg(i > 0, i != 2, i == 1 ? 6'h11 : 6'h20, JIL_TP_NORMAL, 1);
			chk_ila(i > 0, i != 2, i == 1 ? 6'h11 : 6'h20);
		end
		ramp_step = 16'hfff1;
		run_cfg(1'b0, 1'b1, 6'h09, JIL_TP_RAMP, 2);
		run_cfg(1'b0, 1'b0, 6'h09, jil_tp_t'(3'h7), 1);
		run_cfg(1'b0, 1'b0, 6'h09, JIL_TP_D215, 0);
		chk("d215", {k0, l0}, {1'b0, `JIL_D21_5});
		run_cfg(1'b0, 1'b0, 6'h09, JIL_TP_REPILA, 0);
		n0 = 0;
		cycles(180);
		chk("rep_ila", {n0 >= 9, tx_up}, 2'b10);
		for (int o = 0; o < 3; o++) begin
			order = jil_prbs_t'(o);
			run_cfg(1'b0, 1'b0, 6'h09, JIL_TP_PRBS, 0);
			for (int i = 0; i < 254; i++) begin
				hist[i] = l0;
				chk("prbs_k", k0, 1'b0);
				cycles(1);
			end
			for (int i = 0; i < 127; i++) begin
				if (o == 0) chk("prbs7", hist[i + 127], hist[i]);
			end
		end
		run_cfg(1'b0, 1'b0, 6'h09, JIL_TP_K285, 0);
		for (int i = 0; i < 40; i++) begin
			chk("k285", {tx_up, k0, l0}, {2'b01, `JIL_K28_5});
			cycles(1);
		end
		stop_test();
	end
endmodule
`default_nettype wire
